/* design/clc_cell.sv */
// Functional notes
// [RULE1] enable clear forces cell output low
// [RULE2] output status bit reads cell output
// [RULE3] rising edge sets flag when enabled
// [RULE4] falling edge sets flag when enabled
// [RULE5] modes 0-2 are combinational functions
// [RULE6] modes 3-7 are latches and flip-flops
// [RULE7] output invert flips function result
// [RULE8] gate invert bits, gate one lowest
// [RULE9] unused bits ignore writes, read zero
// [RULE10] four five-bit input source selectors
// [RULE11] selector value n routes source n
// [RULE12] empty gate yields its polarity constant
// [RULE13] reset clears control, keeps selection settings
// [RULE14] edge during clear keeps flag set
// [RULE15] edges found by comparing with last output
module clc_cell #(
    parameter int SRC_N = clc_pkg::SRC_N
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic                  hresp,
    output logic [31:0]           hrdata,
    input  wire logic [SRC_N-1:0] src_in,
    output logic                  cell_out,
    output logic                  irq
);

    initial
    begin
        if (SRC_N < 1 || SRC_N > (1 << clc_pkg::SEL_W))
            $error("clc_cell source count out of range");
    end

    localparam int RW = clc_pkg::REG_W;
    localparam int GN = clc_pkg::GATE_N;

    typedef struct packed {
        logic [SRC_N-1:0]           src_s1;
        logic [SRC_N-1:0]           src_s2;
        logic [RW-1:0]              ctrl;
        logic                       out_inv;
        logic                       stat;
        logic                       mask;
        logic                       cell_out;
        logic                       prev_out;
        logic                       irq;
        logic [31:0]                hrdata;
        logic                       hreadyout;
        logic                       hresp;
        logic                       dp_wr;
        logic [clc_pkg::AOFS_W-1:0] dp_addr;
    } clc_st_type;

    // selection and gating settings survive reset
    typedef struct packed {
        logic [GN-1:0]                           gate_inv;
        logic [GN-1:0][clc_pkg::SEL_W-1:0]       sel;
        logic [GN-1:0][clc_pkg::GSEL_W-1:0]      gsel;
    } clc_cfg_type;

    clc_st_type  s_r;
    clc_st_type  s_nxt;
    clc_cfg_type c_r;
    clc_cfg_type c_nxt;

    logic [GN-1:0] data_in;
    logic [GN-1:0] gate_val;
    logic          fn_out;
    logic          addr_take;
    logic          rise_ev;
    logic          fall_ev;
    logic          clr_req;
    logic [31:0]   wd;

    function automatic logic pick_src(input logic [SRC_N-1:0] src,
                                      input logic [clc_pkg::SEL_W-1:0] sel);
        pick_src = (32'(sel) < SRC_N) ? src[sel] : 1'b0; // [RULE11]
    endfunction

    generate
        for (genvar k = 0; k < GN; k++)
        begin : g_lane
            assign data_in[k] = pick_src(s_r.src_s2, c_r.sel[k]); // [RULE10]
            clc_gate #(
                .N_IN (GN)
            ) u_gate (
                .data     (data_in),
                .gsel     (c_r.gsel[k]),
                .invert   (c_r.gate_inv[k]),
                .gate_out (gate_val[k])
            );
        end
    endgenerate

    clc_logic_fn u_fn (
        .hclk    (hclk),
        .hresetn (hresetn),
        .enable  (s_r.ctrl[clc_pkg::CTRL_EN_BIT]),
        .mode    (s_r.ctrl[clc_pkg::MODE_LSB +: clc_pkg::MODE_W]),
        .g       (gate_val),
        .fn_out  (fn_out)
    );

    assign addr_take = hsel & hready & (htrans == clc_pkg::HTRANS_NONSEQ)
                       & (hsize == clc_pkg::HSIZE_WORD);
    assign wd        = hwdata;
    assign clr_req   = s_r.dp_wr & (s_r.dp_addr == clc_pkg::STAT_OFS)
                       & wd[clc_pkg::STAT_IRQ_BIT];
    // compare current output with last one seen
    assign rise_ev   = s_r.cell_out & ~s_r.prev_out // [RULE15]
                       & s_r.ctrl[clc_pkg::CTRL_RISE_BIT]; // [RULE3]
    assign fall_ev   = ~s_r.cell_out & s_r.prev_out
                       & s_r.ctrl[clc_pkg::CTRL_FALL_BIT]; // [RULE4]

    always_comb
    begin
        s_nxt           = s_r;
        c_nxt           = c_r;
        s_nxt.src_s1    = src_in;
        s_nxt.src_s2    = s_r.src_s1;
        s_nxt.hreadyout = 1'b1;
        s_nxt.hresp     = 1'b0;
        s_nxt.dp_wr     = addr_take & hwrite;
        s_nxt.dp_addr   = haddr[clc_pkg::AOFS_W-1:0];

        if (s_r.dp_wr)
        begin
            unique case (s_r.dp_addr)
                clc_pkg::CTRL_OFS:  s_nxt.ctrl = wd[RW-1:0] & clc_pkg::CTRL_WMASK; // [RULE9]
                clc_pkg::POL_OFS:
                begin
                    s_nxt.out_inv  = wd[clc_pkg::POL_OUT_BIT];
                    c_nxt.gate_inv = wd[clc_pkg::POL_G_LSB +: GN]; // [RULE8]
                end
                clc_pkg::SEL0_OFS:  c_nxt.sel[0]  = wd[clc_pkg::SEL_W-1:0];
                clc_pkg::SEL1_OFS:  c_nxt.sel[1]  = wd[clc_pkg::SEL_W-1:0];
                clc_pkg::SEL2_OFS:  c_nxt.sel[2]  = wd[clc_pkg::SEL_W-1:0];
                clc_pkg::SEL3_OFS:  c_nxt.sel[3]  = wd[clc_pkg::SEL_W-1:0];
                clc_pkg::GATE0_OFS: c_nxt.gsel[0] = wd[clc_pkg::GSEL_W-1:0];
                clc_pkg::GATE1_OFS: c_nxt.gsel[1] = wd[clc_pkg::GSEL_W-1:0];
                clc_pkg::GATE2_OFS: c_nxt.gsel[2] = wd[clc_pkg::GSEL_W-1:0];
                clc_pkg::GATE3_OFS: c_nxt.gsel[3] = wd[clc_pkg::GSEL_W-1:0];
                clc_pkg::MASK_OFS:  s_nxt.mask    = wd[clc_pkg::STAT_IRQ_BIT];
                default:            ;
            endcase
        end

        // set beats the write-one clear
        if (clr_req)
            s_nxt.stat = 1'b0;
        if (rise_ev | fall_ev)
            s_nxt.stat = 1'b1; // [RULE14]
        s_nxt.irq = s_nxt.stat & s_nxt.mask;

        s_nxt.prev_out = s_r.cell_out;
        s_nxt.cell_out = s_r.ctrl[clc_pkg::CTRL_EN_BIT] // [RULE1]
                         & (fn_out ^ s_r.out_inv); // [RULE7]

        // read data except the output bit is taken from the settled next state
        s_nxt.hrdata = '0;
        if (addr_take && !hwrite)
        begin
            unique case (haddr[clc_pkg::AOFS_W-1:0])
                clc_pkg::CTRL_OFS:
                begin
                    s_nxt.hrdata[RW-1:0]                = s_nxt.ctrl;
                    s_nxt.hrdata[clc_pkg::CTRL_OUT_BIT] = s_r.cell_out; // [RULE2]
                end
                clc_pkg::POL_OFS:
                begin
                    s_nxt.hrdata[clc_pkg::POL_OUT_BIT]         = s_nxt.out_inv;
                    s_nxt.hrdata[clc_pkg::POL_G_LSB +: GN]     = c_nxt.gate_inv;
                end
                clc_pkg::SEL0_OFS:  s_nxt.hrdata[clc_pkg::SEL_W-1:0]  = c_nxt.sel[0];
                clc_pkg::SEL1_OFS:  s_nxt.hrdata[clc_pkg::SEL_W-1:0]  = c_nxt.sel[1];
                clc_pkg::SEL2_OFS:  s_nxt.hrdata[clc_pkg::SEL_W-1:0]  = c_nxt.sel[2];
                clc_pkg::SEL3_OFS:  s_nxt.hrdata[clc_pkg::SEL_W-1:0]  = c_nxt.sel[3];
                clc_pkg::GATE0_OFS: s_nxt.hrdata[clc_pkg::GSEL_W-1:0] = c_nxt.gsel[0];
                clc_pkg::GATE1_OFS: s_nxt.hrdata[clc_pkg::GSEL_W-1:0] = c_nxt.gsel[1];
                clc_pkg::GATE2_OFS: s_nxt.hrdata[clc_pkg::GSEL_W-1:0] = c_nxt.gsel[2];
                clc_pkg::GATE3_OFS: s_nxt.hrdata[clc_pkg::GSEL_W-1:0] = c_nxt.gsel[3];
                clc_pkg::STAT_OFS:  s_nxt.hrdata[clc_pkg::STAT_IRQ_BIT] = s_nxt.stat;
                clc_pkg::MASK_OFS:  s_nxt.hrdata[clc_pkg::STAT_IRQ_BIT] = s_nxt.mask;
                default:            s_nxt.hrdata = '0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_r           <= '0; // [RULE13]
            s_r.ctrl      <= clc_pkg::CTRL_RST;
            s_r.hreadyout <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    // no reset: settings are kept across reset
    always_ff @(posedge hclk)
    begin
        c_r <= c_nxt; // [RULE13]
    end

    assign hreadyout = s_r.hreadyout;
    assign hresp     = s_r.hresp;
    assign hrdata    = s_r.hrdata;
    assign cell_out  = s_r.cell_out;
    assign irq       = s_r.irq;

    dis_out_low_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE1]
        !s_r.ctrl[clc_pkg::CTRL_EN_BIT] |=> !cell_out)
        else $error("cell output high while disabled");

    status_read_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE2]
        (addr_take && !hwrite && haddr[7:0] == clc_pkg::CTRL_OFS)
        |=> hrdata[clc_pkg::CTRL_OUT_BIT] == $past(cell_out))
        else $error("output status bit differs from cell output");

    rise_flag_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE3]
        (cell_out && !s_r.prev_out && s_r.ctrl[clc_pkg::CTRL_RISE_BIT]) |=> s_r.stat)
        else $error("rising edge did not set flag");

    fall_flag_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE4]
        (!cell_out && s_r.prev_out && s_r.ctrl[clc_pkg::CTRL_FALL_BIT]) |=> s_r.stat)
        else $error("falling edge did not set flag");

    flag_cause_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE15]
        $rose(s_r.stat) |-> $past(rise_ev || fall_ev))
        else $error("flag set without an enabled edge");

    out_invert_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE7]
        s_r.ctrl[clc_pkg::CTRL_EN_BIT] |=> cell_out == ($past(fn_out) ^ $past(s_r.out_inv)))
        else $error("output polarity not applied");

    ctrl_unused_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE9]
        (s_r.ctrl & ~clc_pkg::CTRL_WMASK) == '0)
        else $error("unused control bit set");

    clear_set_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE14]
        (clr_req && (rise_ev || fall_ev)) |=> s_r.stat ##1 irq == (s_r.stat && s_r.mask))
        else $error("edge lost during flag clear");

    irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
        irq == (s_r.stat && s_r.mask))
        else $error("interrupt output does not follow status and mask");

    // read-back masks of the implemented bits
    localparam logic [RW-1:0] CTRL_RMASK = clc_pkg::CTRL_WMASK | (RW'(1) << clc_pkg::CTRL_OUT_BIT);
    localparam logic [RW-1:0] POL_RMASK  = (RW'(1) << clc_pkg::POL_OUT_BIT) | RW'((1 << GN) - 1);

    logic                       rd_take;
    logic [clc_pkg::AOFS_W-1:0] rd_ofs;

    assign rd_take = addr_take & ~hwrite;
    assign rd_ofs  = haddr[clc_pkg::AOFS_W-1:0];

    resp_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp)
        else $error("slave answer not ready and okay");

    ctrl_read_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE9]
        (rd_take && rd_ofs == clc_pkg::CTRL_OFS) |=> (hrdata & ~32'(CTRL_RMASK)) == '0)
        else $error("unused control bit read as one");

    pol_read_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE9]
        (rd_take && rd_ofs == clc_pkg::POL_OFS) |=> (hrdata & ~32'(POL_RMASK)) == '0)
        else $error("unused polarity bit read as one");

    sel_read_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE9]
        (rd_take && (rd_ofs == clc_pkg::SEL0_OFS || rd_ofs == clc_pkg::SEL1_OFS
                     || rd_ofs == clc_pkg::SEL2_OFS || rd_ofs == clc_pkg::SEL3_OFS))
        |=> (hrdata >> clc_pkg::SEL_W) == '0)
        else $error("unused selector bit read as one");

    flag_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_take && (rd_ofs == clc_pkg::STAT_OFS || rd_ofs == clc_pkg::MASK_OFS))
        |=> (hrdata >> (clc_pkg::STAT_IRQ_BIT + 1)) == '0)
        else $error("unused flag bit read as one");

    idle_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !rd_take |=> hrdata == '0)
        else $error("read data not zero outside a read");

    gate_const_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE12]
        (c_r.gsel[0] == '0) |-> (gate_val[0] == c_r.gate_inv[0]))
        else $error("empty gate not set by its polarity");

    write_seen_c: cover property (@(posedge hclk) disable iff (!hresetn) s_r.dp_wr);
    rise_seen_c: cover property (@(posedge hclk) disable iff (!hresetn) rise_ev);
    fall_seen_c: cover property (@(posedge hclk) disable iff (!hresetn) fall_ev);
    race_seen_c: cover property (@(posedge hclk) disable iff (!hresetn)
        clr_req && (rise_ev || fall_ev));

endmodule

/* design/clc_gate.sv */
// one data gate: or of enabled true/negated inputs, then polarity
module clc_gate #(
    parameter int N_IN = 4
) (
    input  wire logic [N_IN-1:0]   data,
    input  wire logic [2*N_IN-1:0] gsel,
    input  wire logic              invert,
    output logic                   gate_out
);

    initial
    begin
        if (N_IN < 1) $error("clc_gate needs at least one input");
    end

    logic [N_IN-1:0] term;

    generate
        for (genvar k = 0; k < N_IN; k++)
        begin : g_term
            // bit 2k = negated form, bit 2k+1 = true form
            assign term[k] = (gsel[2*k+1] & data[k]) | (gsel[2*k] & ~data[k]);
        end
    endgenerate

    // no input enabled: constant set by invert alone
    assign gate_out = (|term) ^ invert; // [RULE12] [RULE8]

endmodule

/* design/clc_logic_fn.sv */
module clc_logic_fn (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       enable,
    input  wire logic [2:0] mode,
    input  wire logic [3:0] g,
    output logic            fn_out
);

    typedef struct packed {
        logic q;
        logic clk_prev;
    } clc_fn_st_type;

    clc_fn_st_type s_r;
    clc_fn_st_type s_nxt;

    logic clk_rise;

    always_comb
    begin
        s_nxt          = s_r;
        s_nxt.clk_prev = g[0];
        clk_rise       = g[0] & ~s_r.clk_prev;
        fn_out         = 1'b0;
        unique case (clc_pkg::clc_mode_type'(mode)) // [RULE5] [RULE6]
            clc_pkg::MODE_AND_OR:   fn_out = (g[0] & g[1]) | (g[2] & g[3]);
            clc_pkg::MODE_OR_XOR:   fn_out = (g[0] | g[1]) ^ (g[2] | g[3]);
            clc_pkg::MODE_AND4:     fn_out = &g;
            clc_pkg::MODE_SR_LATCH:
            begin
                if (g[0] | g[1])
                    s_nxt.q = 1'b1;
                else if (g[2] | g[3])
                    s_nxt.q = 1'b0;
            end
            clc_pkg::MODE_DFF_SR:
            begin
                if (g[3])
                    s_nxt.q = 1'b1;
                else if (g[2])
                    s_nxt.q = 1'b0;
                else if (clk_rise)
                    s_nxt.q = g[1];
            end
            clc_pkg::MODE_DFF2_R:
            begin
                if (g[2])
                    s_nxt.q = 1'b0;
                else if (clk_rise)
                    s_nxt.q = g[1] & g[3];
            end
            clc_pkg::MODE_JK_R:
            begin
                if (g[2])
                    s_nxt.q = 1'b0;
                else if (clk_rise)
                    s_nxt.q = (g[1] & ~s_r.q) | (~g[3] & s_r.q);
            end
            clc_pkg::MODE_LATCH_SR:
            begin
                if (g[3])
                    s_nxt.q = 1'b1;
                else if (g[0])
                    s_nxt.q = 1'b0;
                else if (g[2])
                    s_nxt.q = g[1];
            end
        endcase
        if (!enable)
            s_nxt.q = 1'b0;
        if (mode >= 3'(clc_pkg::MODE_SR_LATCH))
            fn_out = s_nxt.q;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    and4_mode_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE5]
        (mode == 3'(clc_pkg::MODE_AND4)) |-> (fn_out == (&g)))
        else $error("and mode output wrong");

endmodule

/* design/clc_pkg.sv */
package clc_pkg;

    localparam int REG_W     = 8;
    localparam int SEL_W     = 5;
    localparam int GATE_N    = 4;
    localparam int SRC_N     = 32;
    localparam int GSEL_W    = 2 * GATE_N;
    localparam int AOFS_W    = 8;

    // byte offsets on the bus
    localparam logic [AOFS_W-1:0] CTRL_OFS  = 8'h00;
    localparam logic [AOFS_W-1:0] POL_OFS   = 8'h04;
    localparam logic [AOFS_W-1:0] SEL0_OFS  = 8'h08;
    localparam logic [AOFS_W-1:0] SEL1_OFS  = 8'h0c;
    localparam logic [AOFS_W-1:0] SEL2_OFS  = 8'h10;
    localparam logic [AOFS_W-1:0] SEL3_OFS  = 8'h14;
    localparam logic [AOFS_W-1:0] GATE0_OFS = 8'h18;
    localparam logic [AOFS_W-1:0] GATE1_OFS = 8'h1c;
    localparam logic [AOFS_W-1:0] GATE2_OFS = 8'h20;
    localparam logic [AOFS_W-1:0] GATE3_OFS = 8'h24;
    localparam logic [AOFS_W-1:0] STAT_OFS  = 8'h28;
    localparam logic [AOFS_W-1:0] MASK_OFS  = 8'h2c;

    // cell_control fields
    localparam int CTRL_EN_BIT   = 7;
    localparam int CTRL_OUT_BIT  = 5;
    localparam int CTRL_RISE_BIT = 4;
    localparam int CTRL_FALL_BIT = 3;
    localparam int MODE_LSB      = 0;
    localparam int MODE_W        = 3;
    localparam logic [REG_W-1:0] CTRL_WMASK = 8'h9f;
    localparam logic [REG_W-1:0] CTRL_RST   = 8'h00;

    // cell_polarity fields
    localparam int POL_OUT_BIT = 7;
    localparam int POL_G_LSB   = 0;

    // interrupt status / mask
    localparam int STAT_IRQ_BIT = 0;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] HSIZE_WORD    = 3'b010;

    typedef enum logic [MODE_W-1:0] {
        MODE_AND_OR,
        MODE_OR_XOR,
        MODE_AND4,
        MODE_SR_LATCH,
        MODE_DFF_SR,
        MODE_DFF2_R,
        MODE_JK_R,
        MODE_LATCH_SR
    } clc_mode_type;

endpackage

/* dv/clc_src_model.sv */
// internal sources and pins feeding the cell; slow adds one cycle of lag
module clc_src_model #(
    parameter int SRC_N = 32
) (
    input  wire logic             hclk,
    input  wire logic [SRC_N-1:0] level,
    input  wire logic             slow,
    output logic [SRC_N-1:0]      src_in
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [SRC_N-1:0] stage_r;

    always_ff @(posedge hclk)
    begin
        stage_r <= level;
        src_in  <= slow ? stage_r : level;
    end
endmodule

/* dv/configurable_logic_cell_ctrl_bench.sv */
module configurable_logic_cell_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [31:0] level;
    logic        slow;
    logic [31:0] src_in;
    logic        cell_out;
    logic        irq;
    int          miscompares;
    int          cmp_count;

    clc_cell #(.SRC_N(32)) clc_cell_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .src_in(src_in),
        .cell_out(cell_out), .irq(irq));

    clc_src_model #(.SRC_N(32)) clc_src_model_i (
        .hclk(hclk), .level(level), .slow(slow), .src_in(src_in));

    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one edge, then more while the slave holds hready low
    task automatic bus_wait;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 64)
        begin
            @(posedge hclk);
            n++;
        end
        if (n >= 64)
            miscompares++;
    endtask

    task automatic xfer(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= is_wr;
        htrans <= clc_pkg::HTRANS_NONSEQ;
        bus_wait;
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= is_wr ? d : 32'h0;
        bus_wait;
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        cmp(what, exp, q);
    endtask

    task automatic poke(input logic [7:0] a, input logic [31:0] d);
        wr(a, d);
        repeat (4) @(posedge hclk);
    endtask

    task automatic run_cell(input logic [7:0] ctrl, input logic [7:0] pol, input logic exp);
        wr(clc_pkg::CTRL_OFS, {24'h0, ctrl});
        poke(clc_pkg::POL_OFS, {24'h0, pol});
        cmp("cell_out", {31'h0, exp}, {31'h0, cell_out});
        rdc("cell_control", clc_pkg::CTRL_OFS, {24'h0, ctrl | {2'h0, exp, 5'h0}});
    endtask

    function automatic logic comb_fn(input logic [2:0] m, input logic [3:0] g);
        case (m)
            3'h0: return (g[0] & g[1]) | (g[2] & g[3]);
            3'h1: return (g[0] | g[1]) ^ (g[2] | g[3]);
            default: return &g;
        endcase
    endfunction

    task automatic t_regs;
        rdc("cell_control", clc_pkg::CTRL_OFS, 32'h0);
        rdc("status", clc_pkg::STAT_OFS, 32'h0);
        rdc("mask", clc_pkg::MASK_OFS, 32'h0);
        rdc("unmapped", 8'h30, 32'h0);
        for (int k = 0; k < 4; k++)
        begin
            wr(clc_pkg::GATE0_OFS + 8'(4 * k), 32'h0);
            wr(clc_pkg::SEL0_OFS + 8'(4 * k), 32'hffffffff);
            rdc("select", clc_pkg::SEL0_OFS + 8'(4 * k), 32'h1f);
        end
        wr(clc_pkg::POL_OFS, 32'hffffffff);
        rdc("cell_polarity", clc_pkg::POL_OFS, 32'h8f);
        wr(clc_pkg::CTRL_OFS, 32'hffffff67);
        rdc("cell_control", clc_pkg::CTRL_OFS, 32'h07);
    endtask

    task automatic t_comb;
        for (int m = 0; m < 3; m++)
            for (int v = 0; v < 32; v++)
                run_cell(8'h80 | 8'(m), {v[4], 3'h0, v[3:0]},
                         comb_fn(3'(m), v[3:0]) ^ v[4]);
        run_cell(8'h02, 8'h8f, 1'b0);
        run_cell(8'h02, 8'h80, 1'b0);
    endtask

    task automatic t_route;
        for (int k = 0; k < 4; k++)
        begin
            slow <= (k >= 2);
            wr(clc_pkg::GATE0_OFS, 32'h1 << (2 * k + 1));
            for (int n = 0; n < 32; n++)
            begin
                wr(clc_pkg::SEL0_OFS + 8'(4 * k), 32'(n));
                level <= 32'h1 << n;
                run_cell(8'h82, 8'h0e, 1'b1);
                level <= ~(32'h1 << n);
                run_cell(8'h82, 8'h0e, 1'b0);
            end
            wr(clc_pkg::GATE0_OFS, 32'h1 << (2 * k));
            level <= 32'h0;
            run_cell(8'h82, 8'h0e, 1'b1);
        end
    endtask

    // entry: expected output, mode, gate invert bits
    task automatic t_seq;
        logic [7:0] tab [29] = '{8'h34, 8'hb1, 8'hb0, 8'h34, 8'h30,
            8'h44, 8'h42, 8'hc3, 8'hc0, 8'h44, 8'hc8,
            8'h54, 8'h5a, 8'hdb, 8'hd3, 8'hd2, 8'h53,
            8'h64, 8'h62, 8'he3, 8'hea, 8'h6b, 8'h6a, 8'heb,
            8'h71, 8'hf6, 8'hf2, 8'h74, 8'hf8};
        wr(clc_pkg::GATE0_OFS, 32'h0);
        foreach (tab[i])
            run_cell({5'h10, tab[i][6:4]}, {4'h0, tab[i][3:0]}, tab[i][7]);
    endtask

    task automatic t_irq;
        poke(clc_pkg::CTRL_OFS, 32'h0);
        poke(clc_pkg::POL_OFS, 32'h0f);
        wr(clc_pkg::MASK_OFS, 32'h1);
        poke(clc_pkg::STAT_OFS, 32'h1);
        poke(clc_pkg::CTRL_OFS, 32'h92);
        rdc("status", clc_pkg::STAT_OFS, 32'h1);
        cmp("irq", 32'h1, {31'h0, irq});
        poke(clc_pkg::STAT_OFS, 32'h1);
        rdc("status", clc_pkg::STAT_OFS, 32'h0);
        cmp("irq", 32'h0, {31'h0, irq});
        poke(clc_pkg::POL_OFS, 32'h8f);
        rdc("status", clc_pkg::STAT_OFS, 32'h0);
        poke(clc_pkg::CTRL_OFS, 32'h8a);
        poke(clc_pkg::POL_OFS, 32'h0f);
        rdc("status", clc_pkg::STAT_OFS, 32'h0);
        wr(clc_pkg::MASK_OFS, 32'h0);
        poke(clc_pkg::POL_OFS, 32'h8f);
        rdc("status", clc_pkg::STAT_OFS, 32'h1);
        cmp("irq", 32'h0, {31'h0, irq});
        poke(clc_pkg::MASK_OFS, 32'h1);
        cmp("irq", 32'h1, {31'h0, irq});
        poke(clc_pkg::STAT_OFS, 32'h1);
        cmp("irq", 32'h0, {31'h0, irq});
    endtask

    task automatic t_reset;
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        cmp("cell_out", 32'h0, {31'h0, cell_out});
        rdc("cell_control", clc_pkg::CTRL_OFS, 32'h0);
        rdc("cell_polarity", clc_pkg::POL_OFS, 32'h0f);
        rdc("select", clc_pkg::SEL3_OFS, 32'h1f);
        rdc("mask", clc_pkg::MASK_OFS, 32'h0);
    endtask

    initial
    begin
        #2000000;
        miscompares++;
        end_sim;
    end

    initial
    begin
        hresetn     = 1'b0;
        hsel        = 1'b0;
        haddr       = 32'h0;
        htrans      = 2'h0;
        hwrite      = 1'b0;
        hsize       = clc_pkg::HSIZE_WORD;
        hwdata      = 32'h0;
        level       = 32'h0;
        slow        = 1'b0;
        miscompares = 0;
        cmp_count   = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs;
        t_comb;
        t_route;
        t_seq;
        t_irq;
        t_reset;
        end_sim;
    end
endmodule
